// ===== core/torque_limit_selector.sv
// torque limit selector: limit choice, torque clamp, terminal mapping, AHB-Lite registers
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module torque_limit_selector
   import torque_limit_pkg::*;
#(
   parameter int N_IN = NUM_IN_TERM,
   parameter int N_OUT = NUM_OUT_TERM
)(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // input terminals, high = closed (ON)
   input wire logic [N_IN-1:0] in_term_i,
   // torque demand and result
   input wire logic signed [TORQUE_W-1:0] torque_demand_i,
   output logic signed [TORQUE_W-1:0] torque_out_o,
   output logic [N_OUT-1:0] out_term_o,
   output logic irq_o
);

   // elaboration check: one map digit can name at most fifteen terminals
   if (N_IN < 1 || N_IN > (2 ** TERM_W) - 1 || N_OUT < 1 || N_OUT > (2 ** TERM_W) - 1)
   begin : g_bad_term_count
      $error("terminal counts must lie in 1..15");
   end

   // ==========================================================
   // reset release
   logic [1:0] rst_sync_q;
   logic rst_n;

   // two flops so release is clean against the clock
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   // the synchronised copy is the only reset the rest of the block sees
   assign rst_n = rst_sync_q[1];

   // ==========================================================
   // bus address phase capture
   logic wr_pend_q, wr_pend_d;
   logic rd_pend_q, rd_pend_d;
   logic [7:0] addr_q, addr_d;
   logic acc_ok;

   // an address phase counts only while the bus is ready and the slave is selected
   assign acc_ok = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hsize_i == HSIZE_WORD;

   // only whole-word single transfers are decoded; other sizes complete silently
   always_comb
   begin
      wr_pend_d = acc_ok && hwrite_i;
      rd_pend_d = acc_ok && !hwrite_i;
      addr_d = acc_ok ? haddr_i : addr_q;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end
      else
      begin
         wr_pend_q <= wr_pend_d;
         rd_pend_q <= rd_pend_d;
         addr_q <= addr_d;
      end
   end

   // ==========================================================
   // configuration registers
   cfg_t cfg_q, cfg_d;

   // clip a written value into the 0..800 setting range
   function automatic logic [LIMIT_W-1:0] clip_limit(input logic [31:0] v);
      logic [LIMIT_W-1:0] r;
      r = (v > 32'(LIMIT_MAX)) ? LIMIT_MAX : v[LIMIT_W-1:0];
      return r;
   endfunction : clip_limit

   // writes land at the end of the data phase and act next cycle
   always_comb
   begin
      cfg_d = cfg_q;
      if (wr_pend_q)
      begin
         case (addr_q)
            ADDR_FWD_INT: cfg_d.fwd_int = clip_limit(hwdata_i);
            ADDR_REV_INT: cfg_d.rev_int = clip_limit(hwdata_i);
            ADDR_FWD_EXT: cfg_d.fwd_ext = clip_limit(hwdata_i);
            ADDR_REV_EXT: cfg_d.rev_ext = clip_limit(hwdata_i);
            ADDR_MOTOR_MAX: cfg_d.motor_max = clip_limit(hwdata_i);
            ADDR_IN_MAP: cfg_d.in_map = hwdata_i[15:0];
            ADDR_OUT_MAP: cfg_d.out_map = hwdata_i[15:0];
            ADDR_IRQ_MASK: cfg_d.irq_mask = hwdata_i[IRQ_W-1:0];
            default: cfg_d = cfg_q;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_q.fwd_int <= INT_LIMIT_RST;
         cfg_q.rev_int <= INT_LIMIT_RST;
         cfg_q.fwd_ext <= EXT_LIMIT_RST;
         cfg_q.rev_ext <= EXT_LIMIT_RST;
         cfg_q.motor_max <= MOTOR_MAX_RST;
         cfg_q.in_map <= IMAP_RST;
         cfg_q.out_map <= OMAP_RST;
         cfg_q.irq_mask <= '0;
      end
      else
         cfg_q <= cfg_d;
   end

   // ==========================================================
   // request terminal selection
   logic fwd_clamp_request;
   logic rev_clamp_request;

   // pick terminal by map digit; zero or out-of-range means not allocated
   function automatic logic pick_term(input logic [TERM_W-1:0] dig, input logic [N_IN-1:0] t);
      logic r;
      r = 1'b0;
      for (int i = 0; i < N_IN; i++)
         if (dig == 4'(i + 1))
            r = t[i];
      return r;
   endfunction : pick_term

   // terminals are taken as clean levels; no debounce is done in this block
   assign fwd_clamp_request = pick_term(cfg_q.in_map[IMAP_FWD_LSB +: TERM_W], in_term_i);
   assign rev_clamp_request = pick_term(cfg_q.in_map[IMAP_REV_LSB +: TERM_W], in_term_i);

   // ==========================================================
   // active limits
   limits_t lim;
   logic [LIMIT_W-1:0] fwd_sel, rev_sel;

   // the host decides when to close the request terminals
   always_comb
   begin
      fwd_sel = cfg_q.fwd_int;
      if (fwd_clamp_request && cfg_q.fwd_ext < cfg_q.fwd_int)
         fwd_sel = cfg_q.fwd_ext;
      rev_sel = cfg_q.rev_int;
      if (rev_clamp_request && cfg_q.rev_ext < cfg_q.rev_int)
         rev_sel = cfg_q.rev_ext;
      // the motor cannot deliver more than its own maximum
      lim.fwd = (fwd_sel > cfg_q.motor_max) ? cfg_q.motor_max : fwd_sel;
      lim.rev = (rev_sel > cfg_q.motor_max) ? cfg_q.motor_max : rev_sel;
   end

   // ==========================================================
   // torque saturation and clamp flag
   logic signed [TORQUE_W-1:0] torque_d, torque_q;
   logic clamp_d, clamp_q;
   logic signed [TORQUE_W:0] dem_ext, fwd_s, rev_s;

   // sign picks the limit; demand beyond it is cut back to the limit
   always_comb
   begin
      dem_ext = {torque_demand_i[TORQUE_W-1], torque_demand_i};
      fwd_s = (TORQUE_W + 1)'(lim.fwd);
      rev_s = -(TORQUE_W + 1)'(lim.rev);
      torque_d = torque_demand_i;
      clamp_d = 1'b0;
      if (dem_ext >= fwd_s && !torque_demand_i[TORQUE_W-1])
      begin
         torque_d = fwd_s[TORQUE_W-1:0];
         clamp_d = 1'b1;
      end
      else if (dem_ext <= rev_s && torque_demand_i[TORQUE_W-1])
      begin
         torque_d = rev_s[TORQUE_W-1:0];
         clamp_d = 1'b1;
      end
   end

   // ==========================================================
   // output terminals, interrupt status
   logic [N_OUT-1:0] term_d, term_q;
   logic [IRQ_W-1:0] irq_st_d, irq_st_q;
   logic irq_d, irq_q;
   logic st_rd;

   // the clear acts in the data phase, after the read word was captured
   assign st_rd = rd_pend_q && addr_q == ADDR_IRQ_STAT;

   // flag terminal is driven only when the map digit names it
   always_comb
   begin
      for (int i = 0; i < N_OUT; i++)
         term_d[i] = clamp_d && cfg_q.out_map[OMAP_FLAG_LSB +: TERM_W] == 4'(i + 1);
      // read clears, but an edge in the same cycle is kept
      irq_st_d = st_rd ? '0 : irq_st_q;
      if (clamp_d && !clamp_q)
         irq_st_d[IRQ_CLAMP_ON] = 1'b1;
      if (!clamp_d && clamp_q)
         irq_st_d[IRQ_CLAMP_OFF] = 1'b1;
      irq_d = |(irq_st_d & cfg_d.irq_mask);
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         torque_q <= '0;
         clamp_q <= 1'b0;
         term_q <= '0;
         irq_st_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         torque_q <= torque_d;
         clamp_q <= clamp_d;
         term_q <= term_d;
         irq_st_q <= irq_st_d;
         irq_q <= irq_d;
      end
   end

   // ==========================================================
   // read data, registered so hrdata comes from a flop
   logic [31:0] rdata_d, rdata_q;

   // answered one cycle after the address phase, zero wait states
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (rd_pend_d)
      begin
         case (haddr_i)
            ADDR_FWD_INT: rdata_d = 32'(cfg_q.fwd_int);
            ADDR_REV_INT: rdata_d = 32'(cfg_q.rev_int);
            ADDR_FWD_EXT: rdata_d = 32'(cfg_q.fwd_ext);
            ADDR_REV_EXT: rdata_d = 32'(cfg_q.rev_ext);
            ADDR_MOTOR_MAX: rdata_d = 32'(cfg_q.motor_max);
            ADDR_IN_MAP: rdata_d = 32'(cfg_q.in_map);
            ADDR_OUT_MAP: rdata_d = 32'(cfg_q.out_map);
            ADDR_STATUS: rdata_d = 32'({rev_clamp_request, fwd_clamp_request, clamp_q});
            ADDR_IRQ_STAT: rdata_d = 32'(irq_st_q);
            ADDR_IRQ_MASK: rdata_d = 32'(cfg_q.irq_mask);
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= 32'h0000_0000;
      else
         rdata_q <= rdata_d;
   end

   // ==========================================================
   // outputs
   // every output below is a flop copy, so no path runs from input to output
   assign hrdata_o = rdata_q;
   assign hreadyout_o = rst_sync_q[1];   // flop; slave never stalls once out of reset
   assign hresp_o = irq_st_q[0] & 1'b0;  // always OKAY
   assign torque_out_o = torque_q;
   assign out_term_o = term_q;
   assign irq_o = irq_q;

endmodule : torque_limit_selector

// ===== core/torque_limit_pkg.sv
// package: constants, types and register map of the torque limit selector
package torque_limit_pkg;
   // limit settings, percent of rated torque
   localparam int LIMIT_W = 10;
   localparam logic [LIMIT_W-1:0] LIMIT_MAX = 10'h320;        // 800 percent
   localparam logic [LIMIT_W-1:0] INT_LIMIT_RST = 10'h320;    // 800 percent
   localparam logic [LIMIT_W-1:0] EXT_LIMIT_RST = 10'h064;    // 100 percent
   localparam logic [LIMIT_W-1:0] MOTOR_MAX_RST = 10'h12C;    // 300 percent
   // torque demand width (signed, percent)
   localparam int TORQUE_W = 12;
   // terminal mapping
   localparam int TERM_W = 4;
   localparam int NUM_IN_TERM = 8;
   localparam int NUM_OUT_TERM = 3;
   localparam logic [3:0] MAP_NONE = 4'h0;                    // digit value: not allocated
   localparam logic [3:0] MAP_TERM1 = 4'h1;                   // digit value of terminal 1
   localparam int IMAP_FWD_LSB = 8;                           // digit .2
   localparam int IMAP_REV_LSB = 12;                          // digit .3
   localparam int OMAP_FLAG_LSB = 0;                          // digit .0
   localparam logic [15:0] IMAP_RST = 16'h0000;
   localparam logic [15:0] OMAP_RST = 16'h0000;
   // register byte offsets
   localparam logic [7:0] ADDR_FWD_INT = 8'h00;
   localparam logic [7:0] ADDR_REV_INT = 8'h04;
   localparam logic [7:0] ADDR_FWD_EXT = 8'h08;
   localparam logic [7:0] ADDR_REV_EXT = 8'h0C;
   localparam logic [7:0] ADDR_MOTOR_MAX = 8'h10;
   localparam logic [7:0] ADDR_IN_MAP = 8'h14;
   localparam logic [7:0] ADDR_OUT_MAP = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
   // interrupt bits
   localparam int IRQ_W = 2;
   localparam int IRQ_CLAMP_ON = 0;
   localparam int IRQ_CLAMP_OFF = 1;
   // status bits
   localparam int ST_CLAMP = 0;
   localparam int ST_FWD_REQ = 1;
   localparam int ST_REV_REQ = 2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef struct packed {
      logic [LIMIT_W-1:0] fwd_int;
      logic [LIMIT_W-1:0] rev_int;
      logic [LIMIT_W-1:0] fwd_ext;
      logic [LIMIT_W-1:0] rev_ext;
      logic [LIMIT_W-1:0] motor_max;
      logic [15:0] in_map;
      logic [15:0] out_map;
      logic [IRQ_W-1:0] irq_mask;
   } cfg_t;

   typedef struct packed {
      logic [LIMIT_W-1:0] fwd;
      logic [LIMIT_W-1:0] rev;
   } limits_t;
endpackage : torque_limit_pkg

// ===== tb/torque_limit_selector_props.sv
// port checker of the torque limit selector, bound to the top module
`timescale 1ns/1ps
module torque_limit_selector_props
   import torque_limit_pkg::*;
#(
   parameter int N_OUT = NUM_OUT_TERM
)(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic signed [TORQUE_W-1:0] torque_demand_i,
   input wire logic signed [TORQUE_W-1:0] torque_out_o,
   input wire logic [N_OUT-1:0] out_term_o
);
   // ==========
   // helpers
   logic rd_req;
   // a word read taken in this address phase
   assign rd_req = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i
      && hsize_i == HSIZE_WORD;
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);
   sequence settled;
      rstn_i [*4];
   endsequence
   sequence rd_limit;
      rd_req && haddr_i <= ADDR_REV_EXT;
   endsequence
   // ==========
   // assertions
   chk_resp_okay: assert property (hresp_o == 1'b0)
      else $error("bus response not OKAY");
   chk_ready_settled: assert property (settled |-> hreadyout_o)
      else $error("bus stalled after reset release");
   chk_rdata_idle: assert property (!rd_req |=> hrdata_o == 32'h0)
      else $error("read data outside a read data phase");
   chk_unmapped_zero: assert property (rd_req && haddr_i > ADDR_IRQ_MASK |=> hrdata_o == 32'h0)
      else $error("unmapped read not zero");
   chk_limit_range: assert property (rd_limit |=> hrdata_o <= 32'h320)
      else $error("limit setting above 800");
   chk_status_bits: assert property (rd_req && haddr_i == ADDR_STATUS |=> hrdata_o[31:3] == '0)
      else $error("status has stray bits");
   chk_pos_bounded: assert property ($past(torque_demand_i) >= 0 |-> torque_out_o >= 0
      && torque_out_o <= $past(torque_demand_i)) else $error("forward output exceeds demand");
   chk_neg_bounded: assert property ($past(torque_demand_i) < 0 |-> torque_out_o <= 0
      && torque_out_o >= $past(torque_demand_i)) else $error("reverse output exceeds demand");
   chk_term_onehot: assert property ($onehot0(out_term_o))
      else $error("flag on more than one terminal");
endmodule : torque_limit_selector_props
bind torque_limit_selector torque_limit_selector_props #(.N_OUT(N_OUT)) u_props (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i),
   .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .torque_demand_i(torque_demand_i), .torque_out_o(torque_out_o), .out_term_o(out_term_o));

// ===== tb/host_ctrl_model.sv
// host controller model driving the input terminals
`timescale 1ns/1ps
module host_ctrl_model
#(
   parameter int N = 8,
   parameter int FWD_POS = 2,
   parameter int REV_POS = 4
)(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic fwd_want_i,
   input wire logic rev_want_i,
   output logic [N-1:0] term_o
);
   // ==========
   // terminals
   logic [N-1:0] term_d;
   // spare terminals toggle so that only mapped ones may steer the limits
   always_comb
   begin
      term_d = ~term_o;
      term_d[FWD_POS] = fwd_want_i;
      term_d[REV_POS] = rev_want_i;
   end
   // requests change just after the edge, as levels
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         term_o <= '0;
      else
         term_o <= term_d;
endmodule : host_ctrl_model

// ===== tb/torque_limit_selector_test.sv
// self-checking testbench of the torque limit selector
`timescale 1ns/1ps
module torque_limit_selector_test
   import torque_limit_pkg::*;
;
   typedef struct packed {logic sel; logic [7:0] addr; logic [1:0] trans; logic we;} bus_t;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   bus_t bus = '0;
   logic [31:0] hwdata = '0;
   logic signed [TORQUE_W-1:0] demand = '0;
   logic fwd_want = 1'b0;
   logic rev_want = 1'b0;
   logic [31:0] hrdata;
   logic hready;
   logic signed [TORQUE_W-1:0] tout;
   logic [NUM_OUT_TERM-1:0] term;
   logic [NUM_IN_TERM-1:0] in_term;
   logic irq;
   int miscompares = 0;
   int comparisons = 0;
   // ==========
   // clock, design and host
   initial forever #2.5 clk = ~clk;
   torque_limit_selector u_dut (.ref_clk_i(clk), .rstn_i(rstn), .hsel_i(bus.sel),
      .haddr_i(bus.addr), .htrans_i(bus.trans), .hwrite_i(bus.we), .hsize_i(HSIZE_WORD),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(), .in_term_i(in_term), .torque_demand_i(demand), .torque_out_o(tout),
      .out_term_o(term), .irq_o(irq));
   host_ctrl_model u_host (.clk_i(clk), .rstn_i(rstn), .fwd_want_i(fwd_want),
      .rev_want_i(rev_want), .term_o(in_term));
   // ==========
   // tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   // no wait count is assumed; the watchdog ends a stuck bus
   task automatic wait_ready;
      do @(posedge clk); while (hready !== 1'b1);
   endtask : wait_ready
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      bus <= '{1'b1, a, HTRANS_NONSEQ, we};
      wait_ready();
      bus.trans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : xfer
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      xfer(1'b0, a, 32'h0, d);
   endtask : rd_reg
   // extra edges cover the host's own register stage
   task automatic set_dem(input logic signed [TORQUE_W-1:0] d);
      demand <= d;
      repeat (4) @(posedge clk);
   endtask : set_dem
   task automatic reset_values;
      logic [31:0] v;
      rd_reg(ADDR_FWD_INT, v);
      check("fwd_int", v, 32'h320);
      rd_reg(ADDR_FWD_EXT, v);
      check("fwd_ext", v, 32'h064);
      rd_reg(ADDR_REV_EXT, v);
      check("rev_ext", v, 32'h064);
      rd_reg(8'h40, v);
      check("unmapped", v, 32'h0);
      wr_reg(ADDR_REV_INT, 32'h3E7);
      rd_reg(ADDR_REV_INT, v);
      check("rev_int_sat", v, 32'h320);
   endtask : reset_values
   task automatic fwd_path;
      wr_reg(ADDR_FWD_INT, 32'h0FA);
      fwd_want <= 1'b1;
      set_dem(500);
      check("fwd_unmapped", tout, 250);
      wr_reg(ADDR_IN_MAP, 32'h5300);
      set_dem(500);
      check("fwd_req", tout, 100);
      wr_reg(ADDR_FWD_EXT, 32'h0F0);
      set_dem(500);
      check("fwd_ext_live", tout, 240);
      fwd_want <= 1'b0;
      set_dem(500);
      check("fwd_off", tout, 250);
   endtask : fwd_path
   task automatic rev_path;
      logic [31:0] v;
      wr_reg(ADDR_REV_INT, 32'h0C8);
      rev_want <= 1'b1;
      set_dem(-500);
      check("rev_req", tout, -100);
      rd_reg(ADDR_STATUS, v);
      check("status_rev", v, 32'h5);
      rev_want <= 1'b0;
      set_dem(-500);
      check("rev_off", tout, -200);
      wr_reg(ADDR_REV_INT, 32'h320);
      wr_reg(ADDR_REV_EXT, 32'h2BC);
      rev_want <= 1'b1;
      set_dem(-500);
      check("rev_cap", tout, -300);
      rev_want <= 1'b0;
   endtask : rev_path
   task automatic flag_path;
      logic [31:0] v;
      set_dem(50);
      check("small", tout, 50);
      rd_reg(ADDR_STATUS, v);
      check("status_free", v, 32'h0);
      set_dem(500);
      rd_reg(ADDR_STATUS, v);
      check("status_held", v, 32'h1);
      check("term_unmapped", term, 32'h0);
      wr_reg(ADDR_OUT_MAP, 32'h2);
      set_dem(250);
      check("term_equal", term, 32'h2);
      set_dem(249);
      check("term_below", term, 32'h0);
   endtask : flag_path
   task automatic irq_path;
      logic [31:0] v;
      wr_reg(ADDR_IRQ_MASK, 32'h1);
      rd_reg(ADDR_IRQ_STAT, v);
      set_dem(500);
      check("irq_on", irq, 32'h1);
      rd_reg(ADDR_IRQ_STAT, v);
      check("irq_stat_on", v, 32'h1);
      set_dem(0);
      check("irq_masked", irq, 32'h0);
      rd_reg(ADDR_IRQ_STAT, v);
      check("irq_stat_off", v, 32'h2);
   endtask : irq_path
   // ==========
   // main sequence and watchdog
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      reset_values();
      fwd_path();
      rev_path();
      flag_path();
      irq_path();
      summarize();
   end
   // the whole run needs about a hundred cycles
   initial
   begin
      #20us;
      miscompares++;
      summarize();
   end
endmodule : torque_limit_selector_test
